//--- inc/irq_bank_pkg.sv
package irq_bank_pkg;
	// register indices (byte address = index * 4)
	localparam logic [4:0] idx_global_control = 5'h00;
	localparam logic [4:0] idx_enables_base = 5'h01;
	localparam logic [4:0] idx_flags_base = 5'h09;
	localparam logic [4:0] idx_irq_status = 5'h11;
	localparam logic [4:0] idx_irq_mask = 5'h12;
	localparam logic [4:0] idx_last = 5'h12;
	localparam int num_banks = 8;
	// implemented bits per bank (1 = implemented)
	localparam logic [7:0] flag_impl [num_banks] = '{
		8'h31, 8'hC1, 8'h43, 8'hFF, 8'h03, 8'hF1, 8'h03, 8'h31};
	// hardware-mirrored, read-only flag bits (serial buffers, bank 3)
	localparam logic [7:0] flag_ro [num_banks] = '{
		8'h00, 8'h00, 8'h00, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] ctrl_impl = 8'hC1;
	localparam int gie_bit = 7;
	localparam int peripheral_irq_enable_bit = 6;
	localparam int edge_sel_bit = 0;
	localparam logic [7:0] reg_reset = 8'h00;
	// capture unit mode select encoding
	localparam logic [1:0] ccp_mode_capture = 2'h0;
	localparam logic [1:0] ccp_mode_compare = 2'h1;
	localparam logic [1:0] ccp_mode_pwm = 2'h2;
	// bank 5/6/7 bit positions
	localparam int logic_cell1_bit = 4;
	localparam int timer_gate_bit = 0;
	localparam int capture_unit1_bit = 0;
	localparam int capture_unit2_bit = 1;
	localparam int memory_op_bit = 5;
	localparam int osc_rollover_bit = 4;
	localparam int waveform_shutdown_bit = 0;
endpackage : irq_bank_pkg

//--- rtl/edge_detect.sv
`timescale 1ns/1ps
module edge_detect
	import irq_bank_pkg::*;
#(
	parameter int width = 8
)(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [width-1:0] level_in,
	output logic [width-1:0] rise,
	output logic [width-1:0] fall
);
	typedef struct packed {
		logic [width-1:0] prev;
	} state_s;
	state_s s_q;
	state_s s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.prev = level_in;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rise = level_in & ~s_q.prev;
	assign fall = ~level_in & s_q.prev;
endmodule : edge_detect

//--- rtl/flag_cell_bank.sv
`timescale 1ns/1ps
module flag_cell_bank
	import irq_bank_pkg::*;
#(
	parameter logic [7:0] impl = 8'hFF,
	parameter logic [7:0] ro = 8'h00
)(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] hw_set,
	input wire logic [7:0] hw_level,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] flags
);
	typedef struct packed {
		logic [7:0] f;
	} state_s;
	state_s s_q;
	state_s s_d;

	always_comb
	begin
		s_d = s_q;
		for (int i = 0; i < 8; i++)
		begin
			if (ro[i])
				s_d.f[i] = hw_level[i];
			else if (impl[i])
			begin
				if (wr_en)
					s_d.f[i] = wr_data[i];
				if (hw_set[i])
					s_d.f[i] = 1'b1;
			end
			else
				s_d.f[i] = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign flags = s_q.f;
endmodule : flag_cell_bank

//--- rtl/peripheral_interrupt_flag_bank.sv
// Functional notes
// - flags set on their source event regardless of any enable bit
// - flags other than the serial buffer flags are software read/write, hardware set, held until cleared
// - bank 5 bits 7..4 latch logic cell four..one events
// - bank 5 bit 0 sets when timer gate goes inactive
// - unimplemented flag bits always read zero
// - capture mode: unit flag sets on capture
// - compare mode: unit flag sets on compare match, held
// - pwm mode: unit flag sets on output trailing edge, held
// - bank 7 bit 5 sets when memory operation completes
// - bank 7 bit 4 sets on each oscillator rollover
// - bank 7 bit 0 sets when waveform generator enters shutdown
// - all flags reset to zero on every reset
// - serial buffer flags are read-only mirrors of buffer state
`timescale 1ns/1ps
module peripheral_interrupt_flag_bank
	import irq_bank_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [6:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] flags0_event,
	input wire logic [7:0] flags1_event,
	input wire logic [7:0] flags2_event,
	input wire logic [3:0] serial_buffer_state,
	input wire logic [3:0] flags3_event,
	input wire logic [7:0] flags4_event,
	input wire logic [3:0] logic_cell_output,
	input wire logic timer_gate_active,
	input wire logic [1:0] capture_event,
	input wire logic [1:0] compare_match,
	input wire logic [1:0] pwm_output,
	input wire logic [1:0] capture_unit_mode_select [2],
	input wire logic memory_op_done,
	input wire logic oscillator_rollover,
	input wire logic waveform_shutdown,
	output logic cpu_irq,
	output logic external_edge_select,
	output logic irq
);
	typedef struct packed {
		logic [31:0] dat;
		logic ack;
		logic [7:0] ctrl;
		logic [num_banks*8-1:0] en;
		logic [2:0] st;
		logic [2:0] mask;
		logic cpu_irq;
		logic edge_sel;
		logic irq;
	} state_s;
	state_s s_q;
	state_s s_d;

	logic [7:0] flags [num_banks];
	logic [7:0] hw_set [num_banks];
	logic [7:0] hw_level [num_banks];
	logic [7:0] bank_wr;
	logic [3:0] cell_rise;
	logic [3:0] cell_fall_unused;
	logic [0:0] gate_rise_unused;
	logic [0:0] gate_fall;
	logic [1:0] pwm_rise_unused;
	logic [1:0] pwm_fall;
	logic [1:0] shut_rise;
	logic [1:0] shut_fall_unused;
	logic [1:0] ccp_set;
	logic access;
	logic wr_strobe;
	logic [4:0] idx;

	assign access = wb_cyc_i & wb_stb_i & ~s_q.ack;
	assign wr_strobe = access & wb_we_i & wb_sel_i[0];
	assign idx = wb_adr_i[6:2];

	edge_detect #(.width(4)) u_cell_edge (
		.mclk(mclk),
		.reset_n(reset_n),
		.level_in(logic_cell_output),
		.rise(cell_rise),
		.fall(cell_fall_unused)
	);

	edge_detect #(.width(1)) u_gate_edge (
		.mclk(mclk),
		.reset_n(reset_n),
		.level_in(timer_gate_active),
		.rise(gate_rise_unused),
		.fall(gate_fall)
	);

	edge_detect #(.width(2)) u_pwm_edge (
		.mclk(mclk),
		.reset_n(reset_n),
		.level_in(pwm_output),
		.rise(pwm_rise_unused),
		.fall(pwm_fall)
	);

	edge_detect #(.width(2)) u_shut_edge (
		.mclk(mclk),
		.reset_n(reset_n),
		.level_in({1'b0, waveform_shutdown}),
		.rise(shut_rise),
		.fall(shut_fall_unused)
	);

	// per-unit event chosen by mode
	always_comb
	begin
		for (int u = 0; u < 2; u++)
		begin
			case (capture_unit_mode_select[u])
				ccp_mode_capture: ccp_set[u] = capture_event[u];
				ccp_mode_compare: ccp_set[u] = compare_match[u];
				ccp_mode_pwm: ccp_set[u] = pwm_fall[u];
				default: ccp_set[u] = 1'b0;
			endcase
		end
	end

	always_comb
	begin
		for (int b = 0; b < num_banks; b++)
		begin
			hw_set[b] = 8'h00;
			hw_level[b] = 8'h00;
		end
		hw_set[0] = flags0_event;
		hw_set[1] = flags1_event;
		hw_set[2] = flags2_event;
		hw_set[3] = {4'h0, flags3_event};
		hw_level[3] = {serial_buffer_state, 4'h0};
		hw_set[4] = flags4_event;
		hw_set[5][7:logic_cell1_bit] = cell_rise;
		hw_set[5][timer_gate_bit] = gate_fall[0];
		hw_set[6][capture_unit1_bit] = ccp_set[0];
		hw_set[6][capture_unit2_bit] = ccp_set[1];
		hw_set[7][memory_op_bit] = memory_op_done;
		hw_set[7][osc_rollover_bit] = oscillator_rollover;
		hw_set[7][waveform_shutdown_bit] = shut_rise[0];
	end

	genvar g;
	generate
		for (g = 0; g < num_banks; g++)
		begin : g_bank
			assign bank_wr[g] = wr_strobe &&
				(idx == idx_flags_base + 5'(g));
			flag_cell_bank #(
				.impl(flag_impl[g]),
				.ro(flag_ro[g])
			) u_flags (
				.mclk(mclk),
				.reset_n(reset_n),
				.hw_set(hw_set[g]),
				.hw_level(hw_level[g]),
				.wr_en(bank_wr[g]),
				.wr_data(wb_dat_i[7:0]),
				.flags(flags[g])
			);
		end
	endgenerate

	logic [7:0] pend;
	logic [7:0] rd_byte;
	logic [2:0] ev;

	always_comb
	begin
		s_d = s_q;
		pend = 8'h00;
		rd_byte = 8'h00;
		for (int b = 0; b < num_banks; b++)
			pend[b] = |(flags[b] & s_q.en[b*8 +: 8]);
		s_d.cpu_irq = s_q.ctrl[gie_bit] &
			(pend[0] | (s_q.ctrl[peripheral_irq_enable_bit] & |pend[7:1]));
		// events: request rising, enabled flag pending, global enable on
		ev[0] = s_d.cpu_irq & ~s_q.cpu_irq;
		ev[1] = |pend;
		ev[2] = s_q.ctrl[gie_bit];
		s_d.ack = access;
		if (access)
		begin
			if (idx == idx_global_control)
				rd_byte = s_q.ctrl;
			else if (idx >= idx_enables_base && idx < idx_flags_base)
				rd_byte = s_q.en[(idx - idx_enables_base)*8 +: 8];
			else if (idx >= idx_flags_base && idx < idx_irq_status)
				rd_byte = flags[3'(idx - idx_flags_base)];
			else if (idx == idx_irq_status)
				rd_byte = {5'h00, s_q.st};
			else if (idx == idx_irq_mask)
				rd_byte = {5'h00, s_q.mask};
			s_d.dat = {24'h000000, rd_byte};
			if (wr_strobe)
			begin
				if (idx == idx_global_control)
					s_d.ctrl = wb_dat_i[7:0] & ctrl_impl;
				else if (idx >= idx_enables_base && idx < idx_flags_base)
					s_d.en[(idx - idx_enables_base)*8 +: 8] =
						wb_dat_i[7:0] & flag_impl[3'(idx - idx_enables_base)];
				else if (idx == idx_irq_status)
					s_d.st = s_q.st & ~wb_dat_i[2:0];
				else if (idx == idx_irq_mask)
					s_d.mask = wb_dat_i[2:0];
			end
		end
		// set wins over write-one-to-clear
		s_d.st = s_d.st | ev;
		s_d.edge_sel = s_d.ctrl[edge_sel_bit];
		s_d.irq = |(s_d.st & s_d.mask);
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q <= '0;
			s_q.ctrl <= reg_reset;
		end
		else
			s_q <= s_d;
	end

	assign wb_dat_o = s_q.dat;
	assign wb_ack_o = s_q.ack;
	assign cpu_irq = s_q.cpu_irq;
	assign external_edge_select = s_q.edge_sel;
	assign irq = s_q.irq;
endmodule : peripheral_interrupt_flag_bank

//--- sim/irq_bank_chk.sv
`timescale 1ns/1ps
module irq_bank_chk (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [6:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic cpu_irq,
	input wire logic irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	wire rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	wire wr = wb_cyc_i && wb_we_i;
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack timing");
	property p_ack_src;
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_src: assert property (p_ack_src) else $error("stray ack");
	property p_hi;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("upper lanes set");
	property p_unmap;
		rd && wb_adr_i[6:2] > 5'h12 |=> wb_dat_o == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_unimpl6;
		rd && wb_adr_i == 7'h3C |=> wb_dat_o[7:2] == 6'h0;
	endproperty
	a_unimpl6: assert property (p_unimpl6) else $error("bank6 bits");
	property p_unimpl7;
		rd && wb_adr_i == 7'h40 |=> wb_dat_o[7:6] == 2'h0 && wb_dat_o[3:1] == 3'h0;
	endproperty
	a_unimpl7: assert property (p_unimpl7) else $error("bank7 bits");
	property p_reset;
		$rose(reset_n) |-> !cpu_irq && !irq && !wb_ack_o;
	endproperty
	a_reset: assert property (p_reset) else $error("reset outputs");
	property p_sticky;
		$fell(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
	endproperty
	a_sticky: assert property (p_sticky) else $error("irq fell alone");
	c_irq: cover property ($rose(irq));
	c_cpu: cover property ($rose(cpu_irq));
	c_unmap: cover property (rd && wb_adr_i[6:2] > 5'h12);
endmodule : irq_bank_chk
bind peripheral_interrupt_flag_bank irq_bank_chk i_irq_bank_chk (
	.mclk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_o, .wb_ack_o, .cpu_irq, .irq);

//--- sim/event_src.sv
`timescale 1ns/1ps
module event_src (
	input wire logic mclk,
	output logic [3:0] logic_cell_output,
	output logic timer_gate_active,
	output logic [1:0] capture_event,
	output logic [1:0] compare_match,
	output logic [1:0] pwm_output,
	output logic memory_op_done,
	output logic oscillator_rollover,
	output logic waveform_shutdown
);
	logic [13:0] v = '0;
	assign {waveform_shutdown, oscillator_rollover, memory_op_done,
		pwm_output, compare_match, capture_event, timer_gate_active,
		logic_cell_output} = v;
	// raise line k for one cycle, or leave it up
	task fire(input int k, input bit hold);
		@(posedge mclk);
		v[k] <= 1'b1;
		@(posedge mclk);
		if (!hold)
			v[k] <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : fire
endmodule : event_src

//--- sim/tb_peripheral_interrupt_flag_bank.sv
`timescale 1ns/1ps
module tb_peripheral_interrupt_flag_bank;
	import irq_bank_pkg::*;
	logic mclk, reset_n, cyc, stb, we, ack, cpu_irq, ees, irq;
	logic [6:0] adr;
	logic [31:0] wd, dato, rdat;
	logic [7:0] f0;
	logic [3:0] f3s, lc;
	logic [1:0] mode [2];
	logic [1:0] cap, cmp, pwm;
	logic tg, mem, osc, cwg;
	int failures = 0;
	int tests_run = 0;
	localparam logic [1:0] modes [3] = '{ccp_mode_capture, ccp_mode_compare,
		ccp_mode_pwm};
	peripheral_interrupt_flag_bank i_peripheral_interrupt_flag_bank (
		.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
		.wb_dat_o(dato), .wb_ack_o(ack), .flags0_event(f0),
		.flags1_event(8'h00), .flags2_event(8'h00), .serial_buffer_state(f3s),
		.flags3_event(4'h0), .flags4_event(8'h00), .logic_cell_output(lc),
		.timer_gate_active(tg), .capture_event(cap), .compare_match(cmp),
		.pwm_output(pwm), .capture_unit_mode_select(mode),
		.memory_op_done(mem), .oscillator_rollover(osc),
		.waveform_shutdown(cwg), .cpu_irq(cpu_irq),
		.external_edge_select(ees), .irq(irq));
	event_src i_event_src (.mclk(mclk), .logic_cell_output(lc),
		.timer_gate_active(tg), .capture_event(cap), .compare_match(cmp),
		.pwm_output(pwm), .memory_op_done(mem), .oscillator_rollover(osc),
		.waveform_shutdown(cwg));
	task stop_test;
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task bus(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		{cyc, stb, we, adr, wd} <= {2'h3, w, a, 24'h0, d};
		@(posedge mclk iff ack);
		rdat = dato;
		{cyc, stb} <= 2'h0;
	endtask : bus
	task rd(input logic [6:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rdat, {24'h0, e});
	endtask : rd
	// let request and status pipeline settle first
	task pins(input logic c, input logic i, input logic e);
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk({29'h0, cpu_irq, irq, ees}, {29'h0, c, i, e});
	endtask : pins
	task t_bank5;
		i_event_src.fire(4, 0);
		rd(7'h38, 8'h01);
		bus(1'b1, 7'h38, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			i_event_src.fire(k, 0);
			rd(7'h38, 8'h10 << k);
			bus(1'b1, 7'h38, 8'h00);
		end
	endtask : t_bank5
	task t_ccp;
		for (int m = 0; m < 3; m++)
			for (int u = 0; u < 2; u++)
			begin
				mode[u] <= modes[m];
				i_event_src.fire(5 + 2 * m + u, 0);
				rd(7'h3C, 8'h01 << u);
				bus(1'b1, 7'h3C, 8'h00);
			end
	endtask : t_ccp
	task t_bank7;
		i_event_src.fire(11, 0);
		i_event_src.fire(12, 0);
		i_event_src.fire(13, 1);
		rd(7'h40, 8'h31);
		bus(1'b1, 7'h40, 8'h00);
		rd(7'h40, 8'h00);
		bus(1'b1, 7'h40, 8'hFF);
		rd(7'h40, 8'h31);
		i_event_src.fire(13, 0);
	endtask : t_bank7
	task t_serial;
		f3s <= 4'h5;
		bus(1'b1, 7'h30, 8'hFF);
		rd(7'h30, 8'h5F);
		bus(1'b1, 7'h30, 8'h00);
		rd(7'h30, 8'h50);
	endtask : t_serial
	task t_irq;
		f0 <= 8'h01;
		@(posedge mclk);
		f0 <= 8'h00;
		rd(7'h24, 8'h01);
		pins(0, 0, 0);
		bus(1'b1, 7'h24, 8'h00);
		bus(1'b1, 7'h04, 8'h01);
		bus(1'b1, 7'h00, 8'h81);
		pins(0, 0, 1);
		bus(1'b1, 7'h24, 8'h01);
		bus(1'b1, 7'h48, 8'h01);
		pins(1, 1, 1);
		bus(1'b1, 7'h44, 8'h01);
		pins(1, 0, 1);
		bus(1'b1, 7'h24, 8'h00);
		bus(1'b1, 7'h38, 8'h01);
		bus(1'b1, 7'h18, 8'h01);
		pins(0, 0, 1);
		bus(1'b1, 7'h00, 8'hC0);
		pins(1, 1, 0);
		bus(1'b1, 7'h00, 8'h40);
		pins(0, 1, 0);
		bus(1'b1, 7'h48, 8'h00);
		pins(0, 0, 0);
	endtask : t_irq
	task t_reset;
		bus(1'b1, 7'h4C, 8'hFF);
		rd(7'h4C, 8'h00);
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		rd(7'h38, 8'h00);
		rd(7'h40, 8'h00);
		pins(0, 0, 0);
	endtask : t_reset
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial
	begin
		#200000;
		failures++;
		stop_test;
	end
	initial
	begin
		{reset_n, cyc, stb, we, adr, wd, f0, f3s} = '0;
		mode = '{2'h3, 2'h3};
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		t_bank5;
		t_ccp;
		t_bank7;
		t_serial;
		t_irq;
		t_reset;
		stop_test;
	end
endmodule : tb_peripheral_interrupt_flag_bank
